// [uart_pkg.sv]
/*
  constants, register map and state encodings of the serial port core.
  assumes a 50 MHz ref_clk and a 32-bit APB register bus.
*/
package uart_pkg;
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  localparam int REF_HZ = 50_000_000;
  localparam int BAUD_REF_HZ = 1_843_200;
  localparam logic [26:0] NCO_STEP = 27'(2 * BAUD_REF_HZ);
  localparam logic [26:0] NCO_MOD = 27'(REF_HZ);
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_PT = 4'h7;
  // ----------------------------------------
  // register word indexes
  // ----------------------------------------
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IER = 4'h1;
  localparam logic [3:0] IDX_FCR = 4'h2;
  localparam logic [3:0] IDX_LCR = 4'h3;
  localparam logic [3:0] IDX_MCR = 4'h4;
  localparam logic [3:0] IDX_LSR = 4'h5;
  localparam logic [3:0] IDX_MSR = 4'h6;
  localparam logic [3:0] IDX_SCR = 4'h7;
  localparam logic [3:0] IDX_GAP = 4'h8;
  localparam logic [3:0] IDX_EVT = 4'h9;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK = 6;
  localparam int LCR_DLAB = 7;
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int MCR_RTS = 1;
  localparam int MCR_AFE = 5;
  localparam int MCR_RS485 = 6;
  localparam int EV_RX = 0;
  localparam int EV_TXE = 1;
  localparam int EV_ERR = 2;
  localparam int EV_CTS = 3;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] DEPTH_FIFO = 6'(FIFO_DEPTH);
  localparam logic [5:0] DEPTH_BYTE = 6'h01;
  localparam logic [5:0] RTS_LEVEL = 6'h1C;
  // ----------------------------------------
  // engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
    TX_PAR = 3'b010, TX_STOP = 3'b110, TX_GAP = 3'b111
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_PAR = 3'b010, RX_STOP = 3'b110
  } rx_state_t;
endpackage : uart_pkg

// [pci_uart_core.sv]
/*
  serial port core: APB registers, baud generator, transmitter and receiver
  with 1-byte or 32-byte holding storage, inter-character gap, rts/cts.
  assumes psel is the decode of the port's single address window and that
  rxd/cts_n come straight from pins.
*/
// Operation
// - reset clears fifo enable; one-byte transmit and receive holding
// - writing fifo control bit 0 as one selects 32-byte fifos
// - rts/cts flow control available in fifo mode
// - 1.8432 MHz reference divided by 16-bit divisor 1..65535
// - divided output is sixteen times the bit rate
// - divisor held as two 8-bit latch bytes
// - writing either divisor byte reloads the baud counter at once
// - divisor 12 gives 9600, divisor 1 gives 115200 bit/s
// - 1.8432 MHz reference clock driven out on a pin
// - five to eight data bits per character
// - even, odd, none, space and mark parity on both directions
// - both directions run about 1.76 to 115200 bit/s
// - registers reached at window base plus their offset
// - one address window acts as chip select for the core
// - programmable idle gap of whole bit times between characters
// - driver enable supports rs232, rs422 and rs485 lines
`timescale 1ns/1ps
module pci_uart_core (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n,
  output logic de,
  output logic uart_clk_o
);
  import uart_pkg::*;

  typedef struct packed {
    logic [26:0] nco;
    logic refclk;
    logic ref_tick;
    logic [7:0] dll;
    logic [7:0] divisor_high_byte;
    logic [15:0] bcnt;
    logic tick;
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [3:0] ier;
    logic fen;
    logic [7:0] scr;
    logic [7:0] gap;
    logic [3:0] evt;
    logic [4:1] err;
    logic dcts;
    logic [2:0] rx_sy;
    logic rx_f;
    logic [2:0] cts_sy;
    logic cts_f;
    logic [FIFO_DEPTH-1:0][7:0] txm;
    logic [4:0] tx_wp;
    logic [4:0] tx_rp;
    logic [5:0] tx_cnt;
    logic [FIFO_DEPTH-1:0][7:0] rxm;
    logic [4:0] rx_wp;
    logic [4:0] rx_rp;
    logic [5:0] rx_cnt;
    tx_state_t tx_st;
    logic [3:0] tx_ph;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic [7:0] tx_gc;
    logic tx_line;
    rx_state_t rx_st;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic txd;
    logic rts_n;
    logic de;
  } state_t;

  state_t s_r, s_nxt;

  // parity bit for a character of the configured length
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] l);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - l[1:0]);
    if (l[LCR_STICK])
      par_bit = ~l[LCR_EPS];
    else
      par_bit = (^(d & m)) ^ ~l[LCR_EPS];
  endfunction : par_bit

  always_comb begin
    state_t n;
    logic [3:0] idx;
    logic mapped, done, rd, wr, dlab, afe, cts;
    logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
    logic [15:0] div;
    logic [5:0] cap;
    logic [7:0] rbyte, rdat;
    logic pe, fe;
    n = s_r;
    idx = paddr[5:2];
    mapped = 1'b0;
    done = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_clr = 1'b0;
    rx_clr = 1'b0;
    rbyte = 8'h00;
    rdat = 8'h00;
    pe = 1'b0;
    fe = 1'b0;
    dlab = s_r.lcr[LCR_DLAB];
    afe = s_r.mcr[MCR_AFE] & s_r.fen;
    cts = ~s_r.cts_f;
    cap = s_r.fen ? DEPTH_FIFO : DEPTH_BYTE;
    div = {s_r.divisor_high_byte, s_r.dll};

    // ----------------------------------------
    // pin synchronisers, change taken when 2nd and 3rd agree
    // ----------------------------------------
    n.rx_sy = {s_r.rx_sy[1:0], rxd};
    n.cts_sy = {s_r.cts_sy[1:0], cts_n};
    if (s_r.rx_sy[1] == s_r.rx_sy[2])
      n.rx_f = s_r.rx_sy[2];
    if (s_r.cts_sy[1] == s_r.cts_sy[2])
      n.cts_f = s_r.cts_sy[2];

    // ----------------------------------------
    // reference and baud generator
    // ----------------------------------------
    // fractional step: edges jitter by one ref_clk, well inside a 16x sample
    n.ref_tick = 1'b0;
    if (s_r.nco + NCO_STEP >= NCO_MOD) begin
      n.nco = s_r.nco + NCO_STEP - NCO_MOD;
      n.refclk = ~s_r.refclk;
      n.ref_tick = ~s_r.refclk;
    end else begin
      n.nco = s_r.nco + NCO_STEP;
    end
    n.tick = 1'b0;
    if (s_r.ref_tick && div != 16'h0000) begin
      if (s_r.bcnt <= 16'h0001) begin
        n.tick = 1'b1;
        n.bcnt = div;
      end else begin
        n.bcnt = s_r.bcnt - 16'h0001;
      end
    end

    // ----------------------------------------
    // apb slave: answer one cycle after setup
    // ----------------------------------------
    mapped = (paddr[11:6] == 6'h00) && (idx <= IDX_EVT);
    n.pready = psel & ~penable;
    if (psel && !penable) begin
      n.pslverr = ~mapped;
      case (idx)
        IDX_DATA: rdat = dlab ? s_r.dll : s_r.rxm[s_r.rx_rp];
        IDX_IER: rdat = dlab ? s_r.divisor_high_byte : {4'h0, s_r.ier};
        IDX_FCR: rdat = {{2{s_r.fen}}, 5'h00, ~s_r.irq};
        IDX_LCR: rdat = s_r.lcr;
        IDX_MCR: rdat = s_r.mcr;
        IDX_LSR: rdat = {1'b0, s_r.tx_cnt == 6'h00 && s_r.tx_st == TX_IDLE,
                         s_r.tx_cnt == 6'h00, s_r.err, s_r.rx_cnt != 6'h00};
        IDX_MSR: rdat = {3'h0, cts, 3'h0, s_r.dcts};
        IDX_SCR: rdat = s_r.scr;
        IDX_GAP: rdat = s_r.gap;
        IDX_EVT: rdat = {4'h0, s_r.evt};
        default: rdat = 8'h00;
      endcase
      n.prdata = mapped ? {24'h000000, rdat} : 32'h00000000;
    end
    done = psel & penable & s_r.pready & ~s_r.pslverr;
    wr = done & pwrite;
    rd = done & ~pwrite;

    // lsr and evt reads clear only what the read reported; msr and data reads clear dcts and pop outright
    if (rd) begin
      case (idx)
        IDX_DATA: rx_pop = ~dlab && s_r.rx_cnt != 6'h00;
        IDX_LSR: n.err = s_r.err & ~s_r.prdata[4:1];
        IDX_MSR: n.dcts = 1'b0;
        IDX_EVT: n.evt = s_r.evt & ~s_r.prdata[3:0];
        default: n.err = n.err;
      endcase
    end
    if (wr) begin
      case (idx)
        IDX_DATA: begin
          if (dlab) begin
            n.dll = pwdata[7:0];
            n.bcnt = {s_r.divisor_high_byte, pwdata[7:0]};
          end else if (s_r.tx_cnt < cap) begin
            tx_push = 1'b1; // full holding storage drops the byte
            n.txm[s_r.tx_wp] = pwdata[7:0];
          end
        end
        IDX_IER: begin
          if (dlab) begin
            n.divisor_high_byte = pwdata[7:0];
            n.bcnt = {pwdata[7:0], s_r.dll};
          end else begin
            n.ier = pwdata[3:0];
          end
        end
        IDX_FCR: begin
          n.fen = pwdata[FCR_EN];
          // a mode change empties both directions
          tx_clr = pwdata[FCR_TXCLR] | (pwdata[FCR_EN] ^ s_r.fen);
          rx_clr = pwdata[FCR_RXCLR] | (pwdata[FCR_EN] ^ s_r.fen);
        end
        IDX_LCR: n.lcr = pwdata[7:0];
        IDX_MCR: n.mcr = pwdata[7:0];
        IDX_SCR: n.scr = pwdata[7:0];
        IDX_GAP: n.gap = pwdata[7:0];
        default: n.scr = n.scr;
      endcase
    end

    // ----------------------------------------
    // transmitter, bit times of sixteen ticks; data spans five to eight bits, stop one or two, gap as many as programmed
    // ----------------------------------------
    if (s_r.tick) begin
      n.tx_ph = s_r.tx_ph + 4'h1;
      case (s_r.tx_st)
        TX_IDLE: begin
          n.tx_ph = 4'h0;
          if (s_r.tx_cnt != 6'h00 && !(afe && !cts)) begin
            tx_pop = 1'b1;
            n.tx_sh = s_r.txm[s_r.tx_rp];
            n.tx_par = par_bit(s_r.txm[s_r.tx_rp], s_r.lcr);
            n.tx_st = TX_START;
            n.tx_line = 1'b0;
          end
        end
        TX_START: begin
          if (s_r.tx_ph == OVS_LAST) begin
            n.tx_st = TX_DATA;
            n.tx_bit = 3'h0;
            n.tx_line = s_r.tx_sh[0];
          end
        end
        TX_DATA: begin
          if (s_r.tx_ph == OVS_LAST) begin
            if (s_r.tx_bit == {1'b1, s_r.lcr[1:0]}) begin
              n.tx_st = s_r.lcr[LCR_PEN] ? TX_PAR : TX_STOP;
              n.tx_line = s_r.lcr[LCR_PEN] ? s_r.tx_par : 1'b1;
              n.tx_bit = 3'h0;
            end else begin
              n.tx_sh = s_r.tx_sh >> 1;
              n.tx_line = s_r.tx_sh[1];
              n.tx_bit = s_r.tx_bit + 3'h1;
            end
          end
        end
        TX_PAR: begin
          if (s_r.tx_ph == OVS_LAST) begin
            n.tx_st = TX_STOP;
            n.tx_line = 1'b1;
          end
        end
        TX_STOP: begin
          if (s_r.tx_ph == OVS_LAST) begin
            if (s_r.lcr[LCR_STOP] && s_r.tx_bit == 3'h0) begin
              n.tx_bit = 3'h1;
            end else begin
              n.tx_gc = 8'h00;
              n.tx_st = (s_r.gap != 8'h00) ? TX_GAP : TX_IDLE;
            end
          end
        end
        TX_GAP: begin
          if (s_r.tx_ph == OVS_LAST) begin
            n.tx_gc = s_r.tx_gc + 8'h01;
            if (s_r.tx_gc + 8'h01 >= s_r.gap)
              n.tx_st = TX_IDLE;
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
    end

    // ----------------------------------------
    // receiver, samples mid-bit at tick seven
    // ----------------------------------------
    if (s_r.tick) begin
      n.rx_ph = s_r.rx_ph + 4'h1;
      case (s_r.rx_st)
        RX_IDLE: begin
          n.rx_ph = 4'h0;
          if (!s_r.rx_f)
            n.rx_st = RX_START;
        end
        RX_START: begin
          // a low shorter than half a bit is noise
          if (s_r.rx_ph == SAMPLE_PT && s_r.rx_f)
            n.rx_st = RX_IDLE;
          if (s_r.rx_ph == OVS_LAST) begin
            n.rx_st = RX_DATA;
            n.rx_bit = 3'h0;
          end
        end
        RX_DATA: begin
          if (s_r.rx_ph == SAMPLE_PT)
            n.rx_sh = {s_r.rx_f, s_r.rx_sh[7:1]};
          if (s_r.rx_ph == OVS_LAST) begin
            n.rx_bit = s_r.rx_bit + 3'h1;
            if (s_r.rx_bit == {1'b1, s_r.lcr[1:0]})
              n.rx_st = s_r.lcr[LCR_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (s_r.rx_ph == SAMPLE_PT)
            n.rx_par = s_r.rx_f;
          if (s_r.rx_ph == OVS_LAST)
            n.rx_st = RX_STOP;
        end
        RX_STOP: begin
          // back to idle at mid stop so the next start edge is caught
          if (s_r.rx_ph == SAMPLE_PT) begin
            n.rx_st = RX_IDLE;
            rbyte = s_r.rx_sh >> (2'h3 - s_r.lcr[1:0]);
            pe = s_r.lcr[LCR_PEN] && (s_r.rx_par != par_bit(rbyte, s_r.lcr));
            fe = ~s_r.rx_f;
            if (s_r.rx_cnt < cap) begin
              rx_push = 1'b1;
              n.rxm[s_r.rx_wp] = rbyte;
            end else begin
              n.err[1] = 1'b1; // overrun: byte lost
            end
            if (pe)
              n.err[2] = 1'b1;
            if (fe)
              n.err[3] = 1'b1;
            if (fe && rbyte == 8'h00)
              n.err[4] = 1'b1;
          end
        end
        default: n.rx_st = RX_IDLE;
      endcase
    end

    // ----------------------------------------
    // storage pointers with clears after moves, events with sets after clears
    // ----------------------------------------
    n.tx_wp = s_r.tx_wp + {4'h0, tx_push};
    n.tx_rp = s_r.tx_rp + {4'h0, tx_pop};
    n.tx_cnt = s_r.tx_cnt + {5'h00, tx_push} - {5'h00, tx_pop};
    n.rx_wp = s_r.rx_wp + {4'h0, rx_push};
    n.rx_rp = s_r.rx_rp + {4'h0, rx_pop};
    n.rx_cnt = s_r.rx_cnt + {5'h00, rx_push} - {5'h00, rx_pop};
    if (tx_clr) begin
      n.tx_wp = 5'h00;
      n.tx_rp = 5'h00;
      n.tx_cnt = 6'h00;
    end
    if (rx_clr) begin
      n.rx_wp = 5'h00;
      n.rx_rp = 5'h00;
      n.rx_cnt = 6'h00;
    end
    if (rx_push)
      n.evt[EV_RX] = 1'b1;
    if (tx_pop && s_r.tx_cnt == 6'h01 && !tx_push)
      n.evt[EV_TXE] = 1'b1;
    if (rx_push ? (pe | fe) : (s_r.rx_st == RX_STOP && s_r.tick
        && s_r.rx_ph == SAMPLE_PT))
      n.evt[EV_ERR] = 1'b1;
    if (s_r.cts_f != n.cts_f) begin
      n.evt[EV_CTS] = 1'b1;
      n.dcts = 1'b1;
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    n.irq = |(n.evt & n.ier);
    n.txd = n.tx_line & ~n.lcr[LCR_BRK];
    // rts drops as the receive side nears full
    n.rts_n = ~(n.mcr[MCR_RTS] & (~afe | (n.rx_cnt < RTS_LEVEL)));
    // rs485 keys the driver only while a frame or gap is on the line
    n.de = ~n.mcr[MCR_RS485] | (n.tx_st != TX_IDLE);
    s_nxt = n;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.lcr <= LCR_RST;
      s_r.mcr <= MCR_RST;
      s_r.rx_sy <= 3'h7;
      s_r.rx_f <= 1'b1;
      s_r.cts_sy <= 3'h7;
      s_r.cts_f <= 1'b1;
      s_r.tx_st <= TX_IDLE;
      s_r.rx_st <= RX_IDLE;
      s_r.tx_line <= 1'b1;
      s_r.txd <= 1'b1;
      s_r.rts_n <= 1'b1;
      s_r.de <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
  assign txd = s_r.txd;
  assign rts_n = s_r.rts_n;
  assign de = s_r.de;
  assign uart_clk_o = s_r.refclk;
endmodule : pci_uart_core

// [uart_props.sv]
/*
  concurrent checks on the serial port core, watching its pins only.
  assumes an apb master that keeps setup then access; bound at the foot.
*/
`timescale 1ns/1ps
module uart_props
  import uart_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic de,
  input wire logic uart_clk_o
);
  // ----------------------------------------
  // register shadows
  // ----------------------------------------
  logic [3:0] idx;
  logic mapped;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic fen_r;
  logic dlab_r;
  logic rts_r;
  logic [7:0] dll_r;
  logic [7:0] dlm_r;
  assign idx = paddr[5:2];
  assign mapped = (paddr[11:6] == 6'h00) && (idx <= IDX_EVT);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && !pslverr;
  assign rd_acc = psel && penable && pready && !pwrite && mapped;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fen_r <= 1'h0;
      dlab_r <= 1'h0;
      rts_r <= 1'h0;
      dll_r <= 8'h00;
      dlm_r <= 8'h00;
    end else if (wr_acc) begin
      if (idx == IDX_FCR) fen_r <= pwdata[FCR_EN];
      if (idx == IDX_LCR) dlab_r <= pwdata[LCR_DLAB];
      if (idx == IDX_MCR) rts_r <= pwdata[MCR_RTS];
      if (idx == IDX_DATA && dlab_r) dll_r <= pwdata[7:0];
      if (idx == IDX_IER && dlab_r) dlm_r <= pwdata[7:0];
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_reset_idle: assert property ($rose(rstn) |-> txd && rts_n && !irq)
    else $error("idle levels wrong after reset");
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready one cycle after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_unmapped_err: assert property (
    setup && !mapped |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  a_fifo_flag_read: assert property (
    rd_acc && idx == IDX_FCR |-> prdata[7:6] == {fen_r, fen_r})
    else $error("fifo mode flags wrong");
  a_divisor_read: assert property (
    rd_acc && dlab_r && idx <= IDX_IER |-> prdata[7:0] == (idx == IDX_DATA ? dll_r : dlm_r))
    else $error("divisor byte read back wrong");
  a_rts_follows: assert property (
    wr_acc && idx == IDX_MCR && !pwdata[MCR_AFE] |-> ##[1:2] rts_n == !rts_r)
    else $error("request to send not following control");
  a_mask_quiet_irq: assert property (
    wr_acc && idx == IDX_IER && !dlab_r && pwdata[3:0] == 4'h0 |-> ##[1:3] !irq)
    else $error("interrupt stays with all masked");
  a_refclk_period: assert property ($rose(uart_clk_o) |-> ##[26:28] $rose(uart_clk_o))
    else $error("reference clock output period wrong");
  c_divisor_write: cover property (wr_acc && dlab_r && idx == IDX_DATA);
  c_fifo_read: cover property (rd_acc && idx == IDX_FCR && fen_r);
  c_unmapped: cover property (setup && !mapped);
endmodule : uart_props

bind pci_uart_core uart_props chk_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .rxd(rxd), .cts_n(cts_n), .txd(txd),
  .rts_n(rts_n), .de(de), .uart_clk_o(uart_clk_o));

// [serial_peer.sv]
/*
  model of the serial device on the far side of the line pins.
  assumes the port runs at the bit time given by BIT_NS.
*/
`timescale 1ns/1ps
module serial_peer #(parameter real BIT_NS = 8680.556) (
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  int nbits = 8;
  bit has_par = 1'h0;
  logic [7:0] got_q[$];
  logic par_q[$];
  logic stop_q[$];
  realtime start_q[$];
  logic [7:0] b;
  logic p;
  initial begin
    rxd = 1'h1; // line idles high
    cts_n = 1'h0;
  end
  // ----------------------------------------
  // receiver, samples mid bit
  // ----------------------------------------
  always begin
    @(negedge txd);
    start_q.push_back($realtime);
    #(BIT_NS / 2.0);
    b = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      #(BIT_NS);
      b[i] = txd; // lsb first
    end
    p = 1'h0;
    if (has_par) begin
      #(BIT_NS);
      p = txd;
    end
    #(BIT_NS);
    got_q.push_back(b);
    par_q.push_back(p);
    stop_q.push_back(txd);
  end
  // ----------------------------------------
  // transmitter, one frame then an idle bit
  // ----------------------------------------
  task automatic send(input logic [7:0] d, input int n, input bit par_on, input logic par);
    rxd = 1'h0; // start bit
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      rxd = d[i];
      #(BIT_NS);
    end
    if (par_on) begin
      rxd = par;
      #(BIT_NS);
    end
    rxd = 1'h1; // stop then idle
    #(2.0 * BIT_NS);
  endtask : send
endmodule : serial_peer

// [tb.sv]
/*
  self-checking bench for the serial port core with an apb master.
  assumes the serial peer model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb;
  import uart_pkg::*;
  localparam real BIT_NS = 16.0e9 / 1843200.0; // divisor 1, 115200 bit/s
  logic ref_clk = 1'h0;
  logic rstn, psel, penable, pwrite, pready, pslverr, irq, rxd, cts_n, txd, rts_n, err, de;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch = 0;
  int checked = 0;
  always #10 ref_clk = ~ref_clk;
  pci_uart_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
    .de(de), .uart_clk_o());
  serial_peer #(.BIT_NS(BIT_NS)) peer_u (.txd(txd), .rxd(rxd), .cts_n(cts_n));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'h1) check("pready", 32'(pready), 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wreg(input logic [3:0] i, input logic [7:0] d);
    apb(1'h1, {6'h00, i, 2'h0}, d);
  endtask : wreg
  task automatic rreg(input logic [3:0] i);
    apb(1'h0, {6'h00, i, 2'h0}, 8'h00);
  endtask : rreg
  task automatic wait_peer(input int k);
    int n;
    n = 0;
    while (peer_u.got_q.size() < k && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    check("frames seen", 32'(peer_u.got_q.size()), 32'(k));
  endtask : wait_peer
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rreg(IDX_FCR);
    check("fifo flags", 32'(rd[7:6]), 32'h0);
    rreg(IDX_LCR);
    check("line control", rd, 32'(LCR_RST));
    apb(1'h0, 12'h028, 8'h00);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'h1, 12'h040, 8'h5A);
    check("outside window err", 32'(err), 32'h1);
    rreg(IDX_LSR);
    check("tx idle", 32'(rd[6:5]), 32'h3);
    check("driver enable", 32'(de), 32'h1);
    wreg(IDX_MCR, 8'h40);
    rreg(IDX_SCR);
    check("rs485 idle", 32'(de), 32'h0);
    wreg(IDX_MCR, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_divisor();
    wreg(IDX_LCR, 8'h83);
    wreg(IDX_DATA, 8'h0C);
    wreg(IDX_IER, 8'h12);
    rreg(IDX_DATA);
    check("divisor low", rd, 32'h0C);
    rreg(IDX_IER);
    check("divisor high", rd, 32'h12);
    wreg(IDX_DATA, 8'h01); // program both bytes first
    wreg(IDX_IER, 8'h00);
    wreg(IDX_LCR, 8'h03);
    rreg(IDX_IER);
    check("mask not divisor", rd, 32'h0);
    $display("divisor test done");
  endtask : t_divisor
  task automatic t_tx();
    logic [7:0] lc[5] = '{8'h00, 8'h19, 8'h0A, 8'h3B, 8'h2F};
    logic [7:0] dv[5] = '{8'h15, 8'h2A, 8'h5B, 8'hC3, 8'h3C};
    logic [7:0] m;
    logic p;
    int nb;
    peer_u.got_q.delete();
    for (int k = 0; k < 5; k++) begin
      nb = int'(lc[k][1:0]) + 5;
      m = dv[k] & 8'((16'h1 << nb) - 16'h1);
      p = lc[k][5] ? !lc[k][4] : (lc[k][4] ? ^m : ~^m);
      peer_u.nbits = nb;
      peer_u.has_par = lc[k][3];
      wreg(IDX_LCR, lc[k]);
      wreg(IDX_DATA, dv[k]);
      wait_peer(k + 1);
      check("tx data", 32'(peer_u.got_q[k]), 32'(m));
      check("tx parity", 32'(peer_u.par_q[k]), 32'(lc[k][3] & p));
      check("tx stop", 32'(peer_u.stop_q[k]), 32'h1);
      do rreg(IDX_LSR); while (rd[6] !== 1'h1 && peer_u.got_q.size() < 9);
    end
    $display("transmit format test done");
  endtask : t_tx
  task automatic t_rx();
    rreg(IDX_EVT);
    wreg(IDX_IER, 8'h04);
    wreg(IDX_LCR, 8'h1B);
    peer_u.send(8'hA7, 8, 1'h1, ^8'hA7);
    check("irq masked", 32'(irq), 32'h0);
    rreg(IDX_LSR);
    check("rx status", 32'(rd[2:0]), 32'h1);
    rreg(IDX_DATA);
    check("rx byte", rd, 32'hA7);
    peer_u.send(8'h3C, 8, 1'h1, ~^8'h3C);
    check("irq on error", 32'(irq), 32'h1);
    rreg(IDX_LSR);
    check("parity error", 32'(rd[2]), 32'h1);
    rreg(IDX_DATA);
    rreg(IDX_EVT);
    check("events", 32'(rd[3:0]), 32'h5);
    rreg(IDX_SCR);
    check("irq cleared", 32'(irq), 32'h0);
    wreg(IDX_IER, 8'h00);
    $display("receive test done");
  endtask : t_rx
  task automatic t_fifo();
    wreg(IDX_LCR, 8'h03);
    peer_u.send(8'h11, 8, 1'h0, 1'h0);
    peer_u.send(8'h22, 8, 1'h0, 1'h0);
    rreg(IDX_LSR);
    check("byte mode overrun", 32'(rd[1:0]), 32'h3);
    rreg(IDX_DATA);
    check("byte mode kept", rd, 32'h11);
    wreg(IDX_FCR, 8'h01);
    rreg(IDX_FCR);
    check("fifo flags on", 32'(rd[7:6]), 32'h3);
    for (int k = 0; k < 3; k++) peer_u.send(8'h31 + 8'(k), 8, 1'h0, 1'h0);
    rreg(IDX_LSR);
    check("fifo no overrun", 32'(rd[1]), 32'h0);
    for (int k = 0; k < 3; k++) begin
      rreg(IDX_DATA);
      check("fifo byte", rd, 32'h31 + 32'(k));
    end
    $display("fifo test done");
  endtask : t_fifo
  task automatic t_gap_flow();
    peer_u.nbits = 8;
    peer_u.has_par = 1'h0;
    peer_u.got_q.delete();
    wreg(IDX_GAP, 8'h03);
    peer_u.start_q.delete();
    wreg(IDX_DATA, 8'h5A);
    wreg(IDX_DATA, 8'hA5);
    wait_peer(2);
    check("frame spacing",
      32'(int'((peer_u.start_q[1] - peer_u.start_q[0]) / BIT_NS)), 32'd13);
    wreg(IDX_MCR, 8'h22);
    peer_u.cts_n <= 1'h1;
    wreg(IDX_DATA, 8'h44);
    // count start bits: a leak past the gap shows well inside the hold
    repeat (3000) @(posedge ref_clk);
    check("held by cts", 32'(peer_u.start_q.size()), 32'h2);
    peer_u.cts_n <= 1'h0;
    wait_peer(3);
    check("released by cts", 32'(peer_u.got_q[2]), 32'h44);
    wreg(IDX_MCR, 8'h02);
    rreg(IDX_SCR);
    check("rts asserted", 32'(rts_n), 32'h0);
    $display("gap and flow test done");
  endtask : t_gap_flow
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rstn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    t_reset();
    t_divisor();
    t_tx();
    t_rx();
    t_fifo();
    t_gap_flow();
    stop_test();
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : tb
